/* design/mrd_pkg.sv */
// constants, types and register map of the motor restart sequencer
package mrd_pkg;

   // =====================================================
   // timing
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned TICK_MS = 100;
   localparam int unsigned TICK_CYC_DEF = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned SEARCH_MAX_MS = 500;
   localparam int unsigned DIP_MAX_MS = 200;
   localparam logic [15:0] SEARCH_TICKS = 16'(SEARCH_MAX_MS / TICK_MS);
   localparam logic [15:0] DIP_TICKS = 16'(DIP_MAX_MS / TICK_MS);
   localparam logic [15:0] COAST_AUTO0 = 16'(500 / TICK_MS);
   localparam logic [15:0] COAST_AUTO1 = 16'(1000 / TICK_MS);
   localparam logic [15:0] COAST_AUTO2 = 16'(3000 / TICK_MS);
   localparam logic [15:0] COAST_AUTO3 = 16'(5000 / TICK_MS);
   localparam logic [7:0] VOLT_FULL = 8'h64;

   // =====================================================
   // register offsets (byte addresses)
   localparam logic [7:0] A_CFG = 8'h00;
   localparam logic [7:0] A_TIME = 8'h04;
   localparam logic [7:0] A_FIRST = 8'h08;
   localparam logic [7:0] A_ACC = 8'h0c;
   localparam logic [7:0] A_FREQ = 8'h10;
   localparam logic [7:0] A_INFN = 8'h14;
   localparam logic [7:0] A_STAT = 8'h18;
   localparam logic [7:0] A_FDET = 8'h1c;

   // =====================================================
   // field positions and codes
   localparam int F_MODE = 0;
   localparam int F_DIR = 4;
   localparam int F_REVP = 6;
   localparam int F_ENC = 8;
   localparam int F_SLV = 9;
   localparam int F_VEC = 10;
   localparam int F_HSL = 11;
   localparam int F_NOCOAST = 13;
   localparam int F_CAP = 14;
   localparam logic [1:0] DIR_NEVER = 2'h0;
   localparam logic [1:0] DIR_ALWAYS = 2'h1;
   localparam logic [1:0] DIR_COND = 2'h2;
   localparam logic [7:0] FN_RESTART_EN = 8'h06;
   localparam int N_TERM = 4;

   // =====================================================
   // reset values
   localparam logic [31:0] R_CFG = 32'h0000_2000;
   localparam logic [31:0] R_TIME = 32'h000a_0000;
   localparam logic [31:0] R_FIRST = 32'h9696_0000;
   localparam logic [31:0] R_ACC = 32'h0032_0032;
   localparam logic [31:0] R_FREQ = 32'h0032_1770;
   localparam logic [31:0] R_INFN = 32'h0000_0000;
   localparam logic [31:0] R_FDET = 32'h0000_1770;

   // =====================================================
   // types
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_DIP = 8'h02,
      ST_SEARCH = 8'h04,
      ST_COAST = 8'h08,
      ST_RAMP = 8'h10,
      ST_ACCEL = 8'h20,
      ST_RUN = 8'h40,
      ST_DECREV = 8'h80
   } mrd_state_e;

   typedef struct packed {
      logic run;
      logic rev;
      logic search_req;
      logic [15:0] freq;
      logic [7:0] volt;
      logic [7:0] stall;
   } mrd_drive_s;

endpackage

/* design/mrd_top.sv */
// restart sequencer for a coasting motor, with wishbone registers
`timescale 1ns/1ps
module mrd_top #(
   parameter int unsigned TICK_CYC = mrd_pkg::TICK_CYC_DEF
) (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic CS_PIN,
   input wire logic [3:0] IN_TERM,
   input wire logic SUPPLY_OK,
   input wire logic START_FWD,
   input wire logic START_REV,
   input wire logic DRIVE_RESET,
   input wire logic RETRY_REQ,
   input wire logic SEARCH_DONE,
   input wire logic [15:0] SEARCH_SPEED,
   input wire logic SEARCH_REV,
   input wire logic [15:0] ENC_SPEED,
   input wire logic ENC_REV,
   output mrd_pkg::mrd_drive_s DRIVE,
   output logic SPEED_REACHED_FLAG,
   output logic FREQUENCY_DETECT_FLAG,
   output logic UNDERVOLTAGE_TRIP,
   output logic SUPPLY_LOSS_TRIP,
   output logic SUPPLY_LOSS_INDICATION
);

   // =====================================================
   // helpers
   // accumulator step: rate add per cycle against a cycle threshold
   function automatic logic [48:0] mrd_bres(input logic [47:0] acc,
      input logic [47:0] add, input logic [47:0] thr);
      logic [47:0] s;
      s = acc + add;
      if (s >= thr) begin
         mrd_bres = {1'b1, s - thr};
      end else begin
         mrd_bres = {1'b0, s};
      end
   endfunction

   function automatic logic [31:0] mrd_wr(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
      for (int i = 0; i < 4; i++) begin
         old[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
      mrd_wr = old;
   endfunction

   // =====================================================
   // pin synchronisers
   logic [9:0] s1_q, s2_q;
   // only the second stage is read anywhere
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         s1_q <= 10'h000;
         s2_q <= 10'h000;
      end else begin
         s1_q <= {RETRY_REQ, DRIVE_RESET, START_REV, START_FWD,
                  SUPPLY_OK, IN_TERM, CS_PIN};
         s2_q <= s1_q;
      end
   end
   logic cs_pin_s, sup_ok, st_fwd, st_rev, drst, retry;
   logic [3:0] term_s;
   assign cs_pin_s = s2_q[0];
   assign term_s = s2_q[4:1];
   assign sup_ok = s2_q[5];
   assign st_fwd = s2_q[6];
   assign st_rev = s2_q[7];
   assign drst = s2_q[8];
   assign retry = s2_q[9];

   // =====================================================
   // registers
   logic [31:0] cfg_q, time_q, first_q, acc_q, freq_q, infn_q, fdet_q;
   logic [31:0] rd_d;
   logic wb_req, wb_wr;
   assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   assign wb_wr = wb_req & WB_WE_I;

   logic [3:0] mode;
   logic [1:0] dir_sel, rev_prev, hsl, cap;
   logic enc_fb, slv, vec, no_coast;
   assign mode = cfg_q[mrd_pkg::F_MODE +: 4];
   assign dir_sel = cfg_q[mrd_pkg::F_DIR +: 2];
   assign rev_prev = cfg_q[mrd_pkg::F_REVP +: 2];
   assign enc_fb = cfg_q[mrd_pkg::F_ENC];
   assign slv = cfg_q[mrd_pkg::F_SLV];
   assign vec = cfg_q[mrd_pkg::F_VEC];
   assign hsl = cfg_q[mrd_pkg::F_HSL +: 2];
   assign no_coast = cfg_q[mrd_pkg::F_NOCOAST];
   assign cap = cfg_q[mrd_pkg::F_CAP +: 2];

   // writes land in the cycle of the acknowledge edge
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         cfg_q <= mrd_pkg::R_CFG;
         time_q <= mrd_pkg::R_TIME;
         first_q <= mrd_pkg::R_FIRST;
         acc_q <= mrd_pkg::R_ACC;
         freq_q <= mrd_pkg::R_FREQ;
         infn_q <= mrd_pkg::R_INFN;
         fdet_q <= mrd_pkg::R_FDET;
      end else if (wb_wr) begin
         if (WB_ADR_I == mrd_pkg::A_CFG) begin
            cfg_q <= mrd_wr(cfg_q, WB_DAT_I, WB_SEL_I);
         end else if (WB_ADR_I == mrd_pkg::A_TIME) begin
            time_q <= mrd_wr(time_q, WB_DAT_I, WB_SEL_I);
         end else if (WB_ADR_I == mrd_pkg::A_FIRST) begin
            first_q <= mrd_wr(first_q, WB_DAT_I, WB_SEL_I);
         end else if (WB_ADR_I == mrd_pkg::A_ACC) begin
            acc_q <= mrd_wr(acc_q, WB_DAT_I, WB_SEL_I);
         end else if (WB_ADR_I == mrd_pkg::A_FREQ) begin
            freq_q <= mrd_wr(freq_q, WB_DAT_I, WB_SEL_I);
         end else if (WB_ADR_I == mrd_pkg::A_INFN) begin
            infn_q <= mrd_wr(infn_q, WB_DAT_I, WB_SEL_I);
         end else if (WB_ADR_I == mrd_pkg::A_FDET) begin
            fdet_q <= mrd_wr(fdet_q, WB_DAT_I, WB_SEL_I);
         end
      end
   end

   // =====================================================
   // arming and mode decode
   logic term_hit;
   // any terminal may carry the enable besides its own pin
   always_comb begin
      term_hit = 1'b0;
      for (int i = 0; i < mrd_pkg::N_TERM; i++) begin
         if (term_s[i] && infn_q[i*8 +: 8] == mrd_pkg::FN_RESTART_EN) begin
            term_hit = 1'b1;
         end
      end
   end
   logic cs_on, hsl_block, armed, inhibit, every, use_enc, use_rv;
   logic dir_det, skip_cush, cmd_on, cmd_rev;
   logic [3:0] m_lo;
   assign cs_on = cs_pin_s | term_hit;
   assign hsl_block = hsl[1];
   assign armed = cs_on & ~no_coast & ~hsl_block;
   assign inhibit = ~no_coast & ~cs_on;
   assign every = mode >= 4'ha;
   assign m_lo = every ? mode - 4'ha : mode;
   assign use_enc = vec | (enc_fb & m_lo == 4'h2);
   assign use_rv = ~use_enc & m_lo == 4'h1;
   assign dir_det = dir_sel == mrd_pkg::DIR_ALWAYS
      | (dir_sel == mrd_pkg::DIR_COND & rev_prev == 2'h0);
   assign skip_cush = use_enc | slv | vec;
   assign cmd_on = st_fwd | st_rev;
   assign cmd_rev = st_rev & ~st_fwd;

   logic [15:0] coast_ticks, cush_ticks, set_f, start_f;
   logic [7:0] fc_time, fc_volt, stall_rs, stall_nm;
   assign cush_ticks = time_q[31:16];
   assign fc_time = first_q[7:0];
   assign fc_volt = first_q[15:8];
   assign stall_rs = first_q[23:16];
   assign stall_nm = first_q[31:24];
   assign set_f = freq_q[15:0];
   assign start_f = freq_q[31:16];
   // zero picks a wait that grows with drive size
   assign coast_ticks = time_q[15:0] != 16'h0000 ? time_q[15:0]
      : cap == 2'h0 ? mrd_pkg::COAST_AUTO0
      : cap == 2'h1 ? mrd_pkg::COAST_AUTO1
      : cap == 2'h2 ? mrd_pkg::COAST_AUTO2
      : mrd_pkg::COAST_AUTO3;

   // =====================================================
   // sequencer state
   mrd_pkg::mrd_state_e st_q, st_d;
   logic [31:0] tk_q, tk_d;
   logic [15:0] tm_q, tm_d, fr_q, fr_d, sto_q, sto_d, dip_q, dip_d;
   logic [7:0] vo_q, vo_d;
   logic [47:0] av_q, av_d, af_q, af_d;
   logic rv_q, rv_d, rst_q, rst_d, first_pend_q, first_pend_d;
   logic pend_q, pend_d, ok_q, ok_d, dec_q, dec_d;
   logic uvt_q, uvt_d, slt_q, slt_d, drst_q, retry_q;
   logic tick, running;
   logic [47:0] thr_cush, thr_acc;
   logic [48:0] bv, bf;
   assign tick = tk_q == TICK_CYC - 1;
   // the restart time has a fixed 0.1 s step whatever the normal one
   assign thr_acc = 48'(rst_q ? acc_q[15:0] : acc_q[31:16])
      * 48'(TICK_CYC);
   assign thr_cush = 48'(cush_ticks) * 48'(TICK_CYC);
   assign bv = mrd_bres(av_q, 48'(mrd_pkg::VOLT_FULL - fc_volt), thr_cush);
   assign bf = mrd_bres(af_q, 48'(set_f), thr_acc);
   assign running = st_q != mrd_pkg::ST_IDLE & st_q != mrd_pkg::ST_DIP;

   // next state of the restart sequencer
   always_comb begin
      st_d = st_q;
      tm_d = tick ? tm_q + 16'h0001 : tm_q;
      fr_d = fr_q;
      vo_d = vo_q;
      rv_d = rv_q;
      av_d = av_q;
      af_d = af_q;
      rst_d = rst_q;
      first_pend_d = first_pend_q;
      pend_d = pend_q | (drst_q & ~drst) | (retry & ~retry_q);
      ok_d = ok_q;
      dec_d = dec_q;
      dip_d = dip_q;
      uvt_d = uvt_q;
      slt_d = slt_q;
      sto_d = (st_q == mrd_pkg::ST_RUN) ? fr_q : sto_q;
      if (drst) begin
         st_d = mrd_pkg::ST_IDLE;
         uvt_d = 1'b0;
         slt_d = 1'b0;
      end else if (!sup_ok && running) begin
         if (armed) begin
            st_d = mrd_pkg::ST_DIP;
            dip_d = 16'h0000;
         end else begin
            st_d = mrd_pkg::ST_IDLE;
            slt_d = 1'b1;
         end
      end else if (running && (!cmd_on || inhibit)) begin
         st_d = mrd_pkg::ST_IDLE;
      end else begin
         case (st_q)
            mrd_pkg::ST_IDLE: begin
               fr_d = 16'h0000;
               vo_d = 8'h00;
               if (retry & ~retry_q) begin
                  uvt_d = 1'b0;
                  slt_d = 1'b0;
               end
               if (!sup_ok && !armed && cmd_on) begin
                  uvt_d = 1'b1; // set outlasts a retry clear
               end
               if (cmd_on && sup_ok && !inhibit && !uvt_q && !slt_q) begin
                  tm_d = 16'h0000;
                  av_d = 48'h0;
                  af_d = 48'h0;
                  pend_d = 1'b0;
                  if (armed && (every || first_pend_q || pend_q)) begin
                     rst_d = 1'b1;
                     ok_d = 1'b0;
                     dec_d = 1'b0;
                     first_pend_d = 1'b0;
                     rv_d = cmd_rev;
                     if (use_rv) begin
                        // stored value is lost after a long dip
                        fr_d = (dip_q >= mrd_pkg::DIP_TICKS
                           || sto_q == 16'h0000) ? start_f : sto_q;
                        if (slv) begin
                           vo_d = mrd_pkg::VOLT_FULL;
                           ok_d = 1'b1;
                           st_d = mrd_pkg::ST_ACCEL;
                        end else begin
                           st_d = mrd_pkg::ST_COAST;
                        end
                     end else if (use_enc) begin
                        fr_d = ENC_SPEED;
                        rv_d = ENC_REV;
                        dec_d = ENC_REV & rev_prev == 2'h1 & ~cmd_rev;
                        st_d = (ENC_REV & rev_prev == 2'h1 & cmd_rev)
                           ? mrd_pkg::ST_IDLE : mrd_pkg::ST_COAST;
                     end else begin
                        st_d = mrd_pkg::ST_SEARCH;
                     end
                  end else begin
                     rst_d = 1'b0;
                     ok_d = 1'b1;
                     fr_d = start_f;
                     rv_d = cmd_rev;
                     vo_d = mrd_pkg::VOLT_FULL;
                     st_d = mrd_pkg::ST_ACCEL;
                  end
               end
            end
            mrd_pkg::ST_DIP: begin
               fr_d = 16'h0000;
               vo_d = 8'h00;
               if (tick && dip_q != 16'hffff) begin
                  dip_d = dip_q + 16'h0001;
               end
               if (sup_ok) begin
                  pend_d = 1'b1;
                  st_d = mrd_pkg::ST_IDLE;
               end
            end
            mrd_pkg::ST_SEARCH: begin
               // a search that never answers gives up at zero speed
               if (SEARCH_DONE || tm_q >= mrd_pkg::SEARCH_TICKS) begin
                  fr_d = SEARCH_DONE ? SEARCH_SPEED : 16'h0000;
                  rv_d = SEARCH_DONE & SEARCH_REV & dir_det;
                  tm_d = 16'h0000;
                  if (rv_d && rev_prev == 2'h1) begin
                     dec_d = ~cmd_rev;
                     st_d = cmd_rev ? mrd_pkg::ST_IDLE
                        : mrd_pkg::ST_COAST;
                  end else begin
                     st_d = mrd_pkg::ST_COAST;
                  end
               end
            end
            mrd_pkg::ST_COAST: begin
               if (tm_q >= coast_ticks) begin
                  tm_d = 16'h0000;
                  vo_d = fc_volt;
                  st_d = mrd_pkg::ST_RAMP;
               end
            end
            mrd_pkg::ST_RAMP: begin
               if (skip_cush || cush_ticks == 16'h0000
                   || vo_q >= mrd_pkg::VOLT_FULL) begin
                  vo_d = mrd_pkg::VOLT_FULL;
                  ok_d = 1'b1;
                  st_d = dec_q ? mrd_pkg::ST_DECREV : mrd_pkg::ST_ACCEL;
               end else if (tm_q >= 16'(fc_time)) begin
                  av_d = bv[47:0];
                  vo_d = vo_q + {7'h00, bv[48]};
               end
            end
            mrd_pkg::ST_DECREV: begin
               if (fr_q == 16'h0000) begin
                  rv_d = 1'b0;
                  st_d = mrd_pkg::ST_ACCEL;
               end else begin
                  af_d = bf[47:0];
                  fr_d = (thr_acc == 48'h0) ? 16'h0000
                     : fr_q - {15'h0000, bf[48]};
               end
            end
            mrd_pkg::ST_ACCEL: begin
               if (fr_q == set_f) begin
                  st_d = mrd_pkg::ST_RUN;
               end else if (thr_acc == 48'h0) begin
                  fr_d = set_f;
               end else begin
                  af_d = bf[47:0];
                  fr_d = fr_q < set_f ? fr_q + {15'h0000, bf[48]}
                     : fr_q - {15'h0000, bf[48]};
               end
            end
            mrd_pkg::ST_RUN: begin
               rst_d = 1'b0;
               fr_d = set_f;
            end
            default: st_d = mrd_pkg::ST_IDLE;
         endcase
      end
      tk_d = (tick || st_d != st_q) ? 32'h0 : tk_q + 32'h1;
      if (st_d != st_q) begin
         tm_d = (st_d == mrd_pkg::ST_RAMP || st_d == mrd_pkg::ST_COAST)
            ? 16'h0000 : tm_d;
      end
   end

   // sequencer flops
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         st_q <= mrd_pkg::ST_IDLE;
         {tk_q, tm_q, fr_q, sto_q, dip_q, vo_q} <= 88'h0;
         {av_q, af_q} <= 96'h0;
         {rv_q, rst_q, pend_q, ok_q, dec_q} <= 5'h00;
         first_pend_q <= 1'b1;
         {uvt_q, slt_q, drst_q, retry_q} <= 4'h0;
      end else begin
         st_q <= st_d;
         {tk_q, tm_q, fr_q, sto_q, dip_q, vo_q} <=
            {tk_d, tm_d, fr_d, sto_d, dip_d, vo_d};
         {av_q, af_q} <= {av_d, af_d};
         {rv_q, rst_q, pend_q, ok_q, dec_q} <=
            {rv_d, rst_d, pend_d, ok_d, dec_d};
         first_pend_q <= first_pend_d;
         {uvt_q, slt_q, drst_q, retry_q} <= {uvt_d, slt_d, drst, retry};
      end
   end

   // =====================================================
   // outputs and read data
   mrd_pkg::mrd_drive_s drv_d;
   logic sr_d, fd_d;
   assign drv_d.run = running;
   assign drv_d.rev = rv_q;
   assign drv_d.search_req = st_q == mrd_pkg::ST_SEARCH;
   assign drv_d.freq = fr_q;
   assign drv_d.volt = vo_q;
   assign drv_d.stall = rst_q ? stall_rs : stall_nm;
   assign sr_d = ok_q & st_q == mrd_pkg::ST_RUN & fr_q == set_f;
   assign fd_d = ok_q & running & fr_q >= fdet_q[15:0];

   // unmapped offsets read as zero
   assign rd_d = WB_ADR_I == mrd_pkg::A_CFG ? cfg_q
      : WB_ADR_I == mrd_pkg::A_TIME ? time_q
      : WB_ADR_I == mrd_pkg::A_FIRST ? first_q
      : WB_ADR_I == mrd_pkg::A_ACC ? acc_q
      : WB_ADR_I == mrd_pkg::A_FREQ ? freq_q
      : WB_ADR_I == mrd_pkg::A_INFN ? infn_q
      : WB_ADR_I == mrd_pkg::A_FDET ? fdet_q
      : WB_ADR_I == mrd_pkg::A_STAT ? {fr_q, 4'h0, first_pend_q,
         slt_q, uvt_q, armed, st_q} : 32'h0;

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         DRIVE <= '0;
         {SPEED_REACHED_FLAG, FREQUENCY_DETECT_FLAG} <= 2'h0;
         {UNDERVOLTAGE_TRIP, SUPPLY_LOSS_TRIP} <= 2'h0;
         SUPPLY_LOSS_INDICATION <= 1'b0;
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0;
      end else begin
         DRIVE <= drv_d;
         {SPEED_REACHED_FLAG, FREQUENCY_DETECT_FLAG} <= {sr_d, fd_d};
         {UNDERVOLTAGE_TRIP, SUPPLY_LOSS_TRIP} <= {uvt_q, slt_q};
         SUPPLY_LOSS_INDICATION <= uvt_q | slt_q;
         WB_ACK_O <= wb_req;
         WB_DAT_O <= wb_req ? rd_d : 32'h0;
      end
   end

endmodule

/* verif/mrd_checker.sv */
// port-level assertions for the restart sequencer
`timescale 1ns/1ps
module mrd_checker (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_ACK_O,
   input wire logic [31:0] WB_DAT_O,
   input wire logic SEARCH_DONE,
   input wire mrd_pkg::mrd_drive_s DRIVE,
   input wire logic SPEED_REACHED_FLAG,
   input wire logic FREQUENCY_DETECT_FLAG,
   input wire logic UNDERVOLTAGE_TRIP,
   input wire logic SUPPLY_LOSS_TRIP,
   input wire logic SUPPLY_LOSS_INDICATION
);
   // ==========
   // checks
   // five ticks of 40 cycles plus a tick and a half of phase slack
   localparam int SMAX = 260;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   // search answered: state leaves, then the output flop follows
   sequence s_search_end;
      ##2 !DRIVE.search_req;
   endsequence
   a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack missing");
   a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
      else $error("read data outside ack");
   a_search_bound: assert property (
      $rose(DRIVE.search_req) |-> ##[1:SMAX] !DRIVE.search_req)
      else $error("speed search too long");
   a_search_reply: assert property (
      SEARCH_DONE && DRIVE.search_req |-> s_search_end)
      else $error("search result not taken");
   a_flags_held: assert property (DRIVE.search_req |->
      !SPEED_REACHED_FLAG && !FREQUENCY_DETECT_FLAG)
      else $error("speed flags during search");
   a_flag_run: assert property ($rose(SPEED_REACHED_FLAG) |-> DRIVE.run)
      else $error("speed flag without output");
   a_ind_trips: assert property (SUPPLY_LOSS_INDICATION ==
      (UNDERVOLTAGE_TRIP || SUPPLY_LOSS_TRIP))
      else $error("indication does not follow trips");
endmodule
bind mrd_top mrd_checker u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
   .WB_DAT_O(WB_DAT_O), .SEARCH_DONE(SEARCH_DONE), .DRIVE(DRIVE),
   .SPEED_REACHED_FLAG(SPEED_REACHED_FLAG),
   .FREQUENCY_DETECT_FLAG(FREQUENCY_DETECT_FLAG),
   .UNDERVOLTAGE_TRIP(UNDERVOLTAGE_TRIP),
   .SUPPLY_LOSS_TRIP(SUPPLY_LOSS_TRIP),
   .SUPPLY_LOSS_INDICATION(SUPPLY_LOSS_INDICATION));

/* verif/mrd_motor_model.sv */
// coasting motor and encoder as seen by the output stage
`timescale 1ns/1ps
module mrd_motor_model #(
   parameter logic [7:0] DLY = 8'h1e,
   parameter logic [15:0] SPD = 16'h0080
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire mrd_pkg::mrd_drive_s drive,
   output logic done,
   output logic [15:0] speed,
   output logic srev,
   output logic [15:0] enc_speed,
   output logic enc_rev
);
   // ==========
   // search answer
   logic [7:0] cnt_q;
   // one pulse per search; count saturates so it never repeats
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 8'h0;
         done <= 1'b0;
      end else begin
         done <= drive.search_req && cnt_q == DLY;
         cnt_q <= drive.search_req ? cnt_q + 8'(cnt_q != 8'hff) : 8'h0;
      end
   end
   // result lines are only valid with done, so show garbage elsewhere
   assign speed = done ? SPD : ~SPD;
   assign srev = ~done;
   assign enc_speed = 16'h0040;
   assign enc_rev = 1'b0;
endmodule

/* verif/mrd_top_bench.sv */
// self-checking bench for the restart sequencer
`timescale 1ns/1ps
module mrd_top_bench;
   logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, cs = 1;
   logic sup = 1, fwd = 0, drst = 0, sdone, srev, erev;
   logic sr, fd, uv, sl, ind;
   logic [7:0] adr = 8'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [3:0] term = 4'h0;
   logic [15:0] sspd, espd;
   mrd_pkg::mrd_drive_s drv;
   int failures = 0, checks = 0;
   always #12.5 clk = ~clk;
   mrd_top #(.TICK_CYC(40)) dut (.CLK_SYS(clk), .NRST(rst_n),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .CS_PIN(cs), .IN_TERM(term), .SUPPLY_OK(sup), .START_FWD(fwd),
      .START_REV(1'b0), .DRIVE_RESET(drst), .RETRY_REQ(1'b0),
      .SEARCH_DONE(sdone), .SEARCH_SPEED(sspd), .SEARCH_REV(srev),
      .ENC_SPEED(espd), .ENC_REV(erev), .DRIVE(drv),
      .SPEED_REACHED_FLAG(sr), .FREQUENCY_DETECT_FLAG(fd),
      .UNDERVOLTAGE_TRIP(uv), .SUPPLY_LOSS_TRIP(sl),
      .SUPPLY_LOSS_INDICATION(ind));
   mrd_motor_model motor (.clk(clk), .rst_n(rst_n), .drive(drv),
      .done(sdone), .speed(sspd), .srev(srev), .enc_speed(espd),
      .enc_rev(erev));
   // ==========
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // classic cycle: hold until ack is sampled, then release
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
      n = 0;
      do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 0; stb <= 0;
      chk(32'(ack), 32'h1);
   endtask
   // bounded wait for one drive bit, level v
   task automatic wait_bit(input int b, input logic v);
      for (int n = 0; n < 3000 && drv[b] !== v; n++) @(posedge clk);
   endtask
   task automatic t_regs;
      wb(0, mrd_pkg::A_CFG, 0); chk(q, mrd_pkg::R_CFG);
      wb(0, mrd_pkg::A_TIME, 0); chk(q, mrd_pkg::R_TIME);
      wb(0, mrd_pkg::A_FIRST, 0); chk(q, mrd_pkg::R_FIRST);
      wb(0, 8'h20, 0); chk(q, 32'h0);
      wb(1, mrd_pkg::A_FDET, 32'h0000_0123);
      wb(0, mrd_pkg::A_FDET, 0); chk(q, 32'h0000_0123);
   endtask
   // mode 0 search: start from the motor speed, then set frequency
   task automatic t_search;
      wb(1, mrd_pkg::A_FREQ, 32'h0010_0100);
      wb(1, mrd_pkg::A_TIME, 32'h0002_0001);
      wb(1, mrd_pkg::A_ACC, 32'h0);
      wb(1, mrd_pkg::A_CFG, 32'h0);
      @(posedge clk) fwd <= 1;
      wait_bit(32, 1); chk(32'(drv.search_req), 32'h1);
      wait_bit(32, 0); repeat (3) @(posedge clk);
      chk(32'(drv.freq), 32'h0080);
      for (int n = 0; n < 3000 && sr !== 1'b1; n++) @(posedge clk);
      chk(32'(sr), 32'h1);
      chk(32'(drv.freq), 32'h0100);
      chk(32'(drv.volt), 32'(mrd_pkg::VOLT_FULL));
      @(posedge clk) fwd <= 0;
      wait_bit(34, 0);
   endtask
   // enable off blocks running; a code-6 terminal enables again
   task automatic t_inhibit;
      @(posedge clk) begin cs <= 0; fwd <= 1; end
      repeat (60) @(posedge clk);
      chk(32'(drv.run), 32'h0);
      wb(1, mrd_pkg::A_INFN, 32'h0000_0600);
      @(posedge clk) term <= 4'h2;
      wait_bit(34, 1); chk(32'(drv.run), 32'h1);
      chk(32'(drv.search_req), 32'h0);
      @(posedge clk) begin fwd <= 0; term <= 4'h0; cs <= 1; end
      wait_bit(34, 0);
   endtask
   // loss while not armed trips; reset clears and rearms restart
   task automatic t_loss;
      wb(1, mrd_pkg::A_CFG, 32'h2000);
      @(posedge clk) fwd <= 1;
      wait_bit(34, 1);
      @(posedge clk) sup <= 0;
      repeat (8) @(posedge clk);
      chk(32'(sl), 32'h1); chk(32'(ind), 32'h1);
      @(posedge clk) begin sup <= 1; fwd <= 0; drst <= 1; end
      repeat (4) @(posedge clk) drst <= 0;
      repeat (6) @(posedge clk);
      chk(32'(sl), 32'h0);
      wb(1, mrd_pkg::A_CFG, 32'h0);
      @(posedge clk) fwd <= 1;
      wait_bit(32, 1); chk(32'(drv.search_req), 32'h1);
      for (int n = 0; n < 3000 && sr !== 1'b1; n++) @(posedge clk);
      chk(32'(sr), 32'h1);
      @(posedge clk) sup <= 0;
      repeat (20) @(posedge clk) sup <= 1;
      repeat (10) @(posedge clk);
      chk(32'(uv | sl), 32'h0);
   endtask
   // mode 11: held frequency, voltage from zero, on every start
   task automatic t_reduced;
      @(posedge clk) fwd <= 0;
      wait_bit(34, 0);
      wb(1, mrd_pkg::A_CFG, 32'h0000_000b);
      @(posedge clk) fwd <= 1;
      wait_bit(34, 1); chk(32'(drv.search_req), 32'h0);
      chk(32'(drv.freq), 32'h0100);
      chk(32'(drv.volt), 32'h0);
   endtask
   task automatic test_done;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // watchdog sized well beyond the slowest scenario
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      test_done();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1;
      t_regs();
      t_search();
      t_inhibit();
      t_loss();
      t_reduced();
      test_done();
   end
endmodule
